// ### acpt_pm1_timer.sv
/*
 * pm1 control register and 24-bit power-management timer, reached by
 * 8-bit system i/o cycles at a base held in configuration registers.
 * assumes the i/o strobes are one-cycle pulses on I_CLK and that the
 * status, enable and firmware bits living elsewhere arrive as levels.
 */
`timescale 1ns/1ns
`default_nettype none
module acpt_pm1_timer (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RESET,
   // system i/o cycle
   input wire logic [15:0] I_IO_ADDR,
   input wire logic I_IO_RD,
   input wire logic I_IO_WR,
   input wire logic [7:0] I_IO_WDATA,
   output logic [7:0] O_IO_RDATA,
   output logic O_IO_HIT,
   // block base from configuration registers
   input wire logic [15:0] I_PM1_BASE,
   // timer clock pin and system state
   input wire logic I_TMR_CLK,
   input wire logic I_WORKING,
   // control bits held in neighbouring registers
   input wire logic I_SMI_ROUTE_ENABLE,
   input wire logic I_BUS_MASTER_CONTROL,
   input wire logic I_FIRMWARE_EVENT_ENABLE,
   input wire logic I_TIMER_CARRY_IRQ_ENABLE,
   input wire logic I_TIMER_RUN_ENABLE,
   input wire logic I_TIMER_CARRY_CLR,
   input wire logic I_FIRMWARE_EVENT_CLR,
   // status and interrupt outputs
   output logic O_TIMER_CARRY_FLAG,
   output logic O_FIRMWARE_EVENT_FLAG,
   output logic [acpt_pkg::TMR_WIDTH-1:0] O_PM_TIMER_COUNT,
   output logic O_SCI_N,
   output logic O_SMI_N
);
   import acpt_pkg::*;

   logic sci_select;
   logic bus_master_reload_enable;
   logic global_release;
   logic [TMR_WIDTH-1:0] pm_timer_count;
   logic [TMR_WIDTH-1:0] next_pm_timer_count;
   logic tmr_tick;
   logic tmr_advance;
   logic [15:0] io_offset;
   logic wr_ctl_main;
   logic pm_event;
   logic bm_event;
   logic fw_event;
   logic next_sci;
   logic next_smi;
   logic [7:0] next_rdata;
   logic next_hit;

   acpt_flag_if carry_if ();
   acpt_flag_if fw_if ();

   // offset of an i/o address inside the block, all ones if below base
   function automatic logic [15:0] block_offset(input logic [15:0] addr,
                                                input logic [15:0] base);
      logic [15:0] diff;
      diff = addr - base;
      if (addr < base) begin
         block_offset = 16'hFFFF;
      end else begin
         block_offset = diff;
      end
   endfunction

   // true when the offset is one this block answers
   function automatic logic is_ours(input logic [15:0] ofs);
      is_ours = (ofs >= OFS_PM1_EN_UPPER) && (ofs <= OFS_TMR_BYTE_SPARE);
   endfunction

   assign io_offset = block_offset(I_IO_ADDR, I_PM1_BASE);
   assign wr_ctl_main = I_IO_WR && (io_offset == OFS_PM1_CTL_MAIN);

   // timer clock pin edges
   acpt_tick u_tick (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_tmr_clk(I_TMR_CLK),
      .o_tick(tmr_tick)
   );

   // main pm1 control register: select and reload enable bits
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         sci_select <= 1'b0;
         bus_master_reload_enable <= 1'b0;
      end else if (wr_ctl_main) begin
         sci_select <= I_IO_WDATA[SCI_SELECT_BIT];
         bus_master_reload_enable <= I_IO_WDATA[BM_RELOAD_BIT];
      end
   end

   // global release: set by writing one, cleared by firmware flag clear
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         global_release <= 1'b0;
      end else if (wr_ctl_main && I_IO_WDATA[GLOBAL_RELEASE_BIT]) begin
         global_release <= 1'b1;
      end else if (I_FIRMWARE_EVENT_CLR) begin
         global_release <= 1'b0;
      end
   end

   // firmware flag set by each release write
   assign fw_if.set = wr_ctl_main && I_IO_WDATA[GLOBAL_RELEASE_BIT];
   assign fw_if.clr = I_FIRMWARE_EVENT_CLR;
   acpt_flag u_fw_flag (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .f(fw_if.owner)
   );

   // timer advances on a pin edge while running and working
   assign tmr_advance = tmr_tick && I_TIMER_RUN_ENABLE
      && I_WORKING;
   assign next_pm_timer_count = pm_timer_count + 24'h00_0001;

   // timer counter; writes never touch it, a stopped pin only holds it
   // no reload path exists, so a restarted pin resumes from the held count
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         pm_timer_count <= TMR_RESET;
      end else if (tmr_advance) begin
         pm_timer_count <= next_pm_timer_count;
      end
   end

   // carry flag on either direction of the top bit
   assign carry_if.set = tmr_advance &&
      (pm_timer_count[TMR_CARRY_BIT] != next_pm_timer_count[TMR_CARRY_BIT]);
   assign carry_if.clr = I_TIMER_CARRY_CLR;
   acpt_flag u_carry_flag (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .f(carry_if.owner)
   );

   // event sources
   assign pm_event = carry_if.flag && I_TIMER_CARRY_IRQ_ENABLE;
   assign bm_event = bus_master_reload_enable && I_BUS_MASTER_CONTROL;
   assign fw_event = fw_if.flag && I_FIRMWARE_EVENT_ENABLE;

   // interrupt routing
   always_comb begin
      next_sci = (sci_select && pm_event) || bm_event;
      next_smi = (!sci_select && I_SMI_ROUTE_ENABLE && pm_event)
         || fw_event;
   end

   // read data mux
   // bytes are read live, so software reading all three may see a tear
   always_comb begin
      next_rdata = REG_ZERO;
      next_hit = I_IO_RD && is_ours(io_offset);
      if (io_offset == OFS_PM1_CTL_MAIN) begin
         next_rdata[SCI_SELECT_BIT] = sci_select;
         next_rdata[BM_RELOAD_BIT] = bus_master_reload_enable;
         next_rdata[GLOBAL_RELEASE_BIT] = global_release;
      end else if (io_offset == OFS_TMR_BYTE_LOW) begin
         next_rdata = pm_timer_count[TMR_LOW_LSB +: 8];
      end else if (io_offset == OFS_TMR_BYTE_MID) begin
         next_rdata = pm_timer_count[TMR_MID_LSB +: 8];
      end else if (io_offset == OFS_TMR_BYTE_HIGH) begin
         next_rdata = pm_timer_count[TMR_HIGH_LSB +: 8];
      end else begin
         next_rdata = REG_ZERO;
      end
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_IO_RDATA <= REG_ZERO;
         O_IO_HIT <= 1'b0;
      end else begin
         O_IO_RDATA <= next_hit ? next_rdata : REG_ZERO;
         O_IO_HIT <= next_hit;
      end
   end

   // interrupt pins, active low
   // registered so the pins never glitch while the decode settles
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_SCI_N <= 1'b1;
         O_SMI_N <= 1'b1;
      end else begin
         O_SCI_N <= !next_sci;
         O_SMI_N <= !next_smi;
      end
   end

   // status copies for the neighbouring registers
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_TIMER_CARRY_FLAG <= 1'b0;
         O_FIRMWARE_EVENT_FLAG <= 1'b0;
         O_PM_TIMER_COUNT <= TMR_RESET;
      end else begin
         O_TIMER_CARRY_FLAG <= carry_if.flag;
         O_FIRMWARE_EVENT_FLAG <= fw_if.flag;
         O_PM_TIMER_COUNT <= next_pm_timer_count;
         if (!tmr_advance) begin
            O_PM_TIMER_COUNT <= pm_timer_count;
         end
      end
   end

   // checks
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RESET);

   AST_RSVD_ZERO: assert property (
      I_IO_RD && (io_offset == OFS_PM1_EN_UPPER ||
         io_offset == OFS_PM1_CTL_SECOND) |=> O_IO_RDATA == REG_ZERO)
      else $error("reserved register read not zero");
   AST_SPARE_ZERO: assert property (
      I_IO_RD && (io_offset == OFS_PM1_CTL_THIRD ||
         io_offset == OFS_PM1_CTL_FOURTH || io_offset == OFS_TMR_BYTE_SPARE)
      |=> O_IO_HIT && O_IO_RDATA == REG_ZERO)
      else $error("spare register read not zero");
   AST_SCI_ROUTE: assert property (
      sci_select && pm_event |=> !O_SCI_N)
      else $error("selected sci not raised");
   AST_SMI_ROUTE: assert property (
      !sci_select && I_SMI_ROUTE_ENABLE && pm_event && !bm_event
      |=> !O_SMI_N && O_SCI_N)
      else $error("smi routing wrong");
   AST_BM_SCI: assert property (
      bus_master_reload_enable && I_BUS_MASTER_CONTROL |=> !O_SCI_N)
      else $error("bus master event missed");
   AST_FW_SMI: assert property (
      wr_ctl_main && I_IO_WDATA[GLOBAL_RELEASE_BIT] &&
      I_FIRMWARE_EVENT_ENABLE ##1 I_FIRMWARE_EVENT_ENABLE |=> !O_SMI_N)
      else $error("release did not raise smi");
   AST_FW_CLEAR: assert property (
      I_FIRMWARE_EVENT_CLR && !fw_if.set |=> !global_release && !fw_if.flag)
      else $error("firmware clear incomplete");
   AST_CARRY_SET: assert property (
      tmr_advance && pm_timer_count[TMR_CARRY_BIT] !=
      next_pm_timer_count[TMR_CARRY_BIT] |=> carry_if.flag)
      else $error("bit 23 change missed");
   AST_CARRY_STICKY: assert property (
      carry_if.flag && !I_TIMER_CARRY_CLR |=> carry_if.flag)
      else $error("carry flag dropped");
   AST_TMR_STEP: assert property (
      !$stable(pm_timer_count) |-> pm_timer_count ==
      $past(pm_timer_count) + 24'h00_0001)
      else $error("timer did not step by one");
   AST_TMR_HOLD: assert property (
      !I_TIMER_RUN_ENABLE |=> $stable(pm_timer_count))
      else $error("stopped timer moved");
   AST_TMR_LOW_BYTE: assert property (
      I_IO_RD && io_offset == OFS_TMR_BYTE_LOW
      |=> O_IO_RDATA == $past(pm_timer_count[7:0]))
      else $error("low timer byte wrong");
   AST_TMR_WRITE: assert property (
      I_IO_WR && !tmr_advance |=> $stable(pm_timer_count))
      else $error("write moved timer");

   // register bus answers
   AST_TMR_MID_BYTE: assert property (
      I_IO_RD && io_offset == OFS_TMR_BYTE_MID
      |=> O_IO_RDATA == $past(pm_timer_count[TMR_MID_LSB +: 8]))
      else $error("middle timer byte wrong");
   AST_TMR_HIGH_BYTE: assert property (
      I_IO_RD && io_offset == OFS_TMR_BYTE_HIGH
      |=> O_IO_RDATA == $past(pm_timer_count[TMR_HIGH_LSB +: 8]))
      else $error("high timer byte wrong");
   AST_OUTSIDE_MISS: assert property (
      I_IO_RD && !is_ours(io_offset)
      |=> !O_IO_HIT && O_IO_RDATA == REG_ZERO)
      else $error("read outside block answered");
   AST_HIT_DROP: assert property (
      !I_IO_RD |=> !O_IO_HIT && O_IO_RDATA == REG_ZERO)
      else $error("read answer without a read");

   // control and release bits
   AST_CTL_WRITE: assert property (
      wr_ctl_main |=> sci_select == $past(I_IO_WDATA[SCI_SELECT_BIT]) &&
      bus_master_reload_enable == $past(I_IO_WDATA[BM_RELOAD_BIT]))
      else $error("control write not taken");
   AST_FW_SET: assert property (
      wr_ctl_main && I_IO_WDATA[GLOBAL_RELEASE_BIT]
      |=> global_release && fw_if.flag)
      else $error("release write did not set flags");
   AST_GR_HOLD: assert property (
      global_release && !I_FIRMWARE_EVENT_CLR |=> global_release)
      else $error("global release dropped");
   AST_FW_COPY: assert property (
      fw_if.flag |=> O_FIRMWARE_EVENT_FLAG)
      else $error("firmware flag copy lost");

   // timer stepping, holding and copies
   AST_TMR_RESET: assert property (
      $fell(I_RESET) |-> pm_timer_count == TMR_RESET)
      else $error("timer not cleared by reset");
   AST_TMR_RUN: assert property (
      tmr_advance
      |=> pm_timer_count == $past(pm_timer_count) + 24'h00_0001)
      else $error("timer missed a tick");
   AST_TMR_IDLE: assert property (
      !I_WORKING |=> $stable(pm_timer_count))
      else $error("timer moved outside working state");
   AST_CNT_COPY: assert property (
      O_PM_TIMER_COUNT == pm_timer_count)
      else $error("count output differs from timer");
   AST_CARRY_COPY: assert property (
      carry_if.flag |=> O_TIMER_CARRY_FLAG)
      else $error("carry flag copy lost");

   // main scenarios seen
   COV_CARRY: cover property (carry_if.set);
   COV_SMI: cover property (!O_SMI_N);
   COV_FW_CLEAR: cover property (fw_if.flag ##1 I_FIRMWARE_EVENT_CLR);
   COV_WRAP: cover property (tmr_advance && pm_timer_count == 24'hFF_FFFF);
endmodule // acpt_pm1_timer
`default_nettype wire

// ### acpt_pkg.sv
/*
 * constants for the pm1 control and power-management timer block:
 * register offsets inside the pm1 block, bit positions, reset values,
 * timer width and clock rates.
 * assumes the host reaches the block through 8-bit system i/o cycles.
 */
package acpt_pkg;
   // register offsets from the pm1 block base
   localparam logic [15:0] OFS_PM1_EN_UPPER = 16'h0003;
   localparam logic [15:0] OFS_PM1_CTL_MAIN = 16'h0004;
   localparam logic [15:0] OFS_PM1_CTL_SECOND = 16'h0005;
   localparam logic [15:0] OFS_PM1_CTL_THIRD = 16'h0006;
   localparam logic [15:0] OFS_PM1_CTL_FOURTH = 16'h0007;
   localparam logic [15:0] OFS_TMR_BYTE_LOW = 16'h0008;
   localparam logic [15:0] OFS_TMR_BYTE_MID = 16'h0009;
   localparam logic [15:0] OFS_TMR_BYTE_HIGH = 16'h000A;
   localparam logic [15:0] OFS_TMR_BYTE_SPARE = 16'h000B;
   // bit positions in the main pm1 control register
   localparam int SCI_SELECT_BIT = 0;
   localparam int BM_RELOAD_BIT = 1;
   localparam int GLOBAL_RELEASE_BIT = 2;
   // timer shape
   localparam int TMR_WIDTH = 24;
   localparam int TMR_CARRY_BIT = 23;
   localparam int TMR_LOW_LSB = 0;
   localparam int TMR_MID_LSB = 8;
   localparam int TMR_HIGH_LSB = 16;
   // values after reset
   localparam logic [7:0] REG_ZERO = 8'h00;
   localparam logic [23:0] TMR_RESET = 24'h00_0000;
   // clock rates in hertz
   localparam int SYS_CLK_HZ = 50000000;
   localparam int TMR_CLK_HZ = 3579545;
   // system clocks per timer clock, rounded down (least high or low time)
   localparam int TMR_CLK_RATIO = SYS_CLK_HZ / TMR_CLK_HZ;
endpackage

// ### acpt_flag_if.sv
/*
 * carrier for one sticky status flag: set event, clear event, flag.
 * assumes both ends run on the block clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface acpt_flag_if;
   logic set;
   logic clr;
   logic flag;
   modport owner (input set, input clr, output flag);
   modport user (output set, output clr, input flag);
endinterface
`default_nettype wire

// ### acpt_flag.sv
/*
 * sticky flag: set by hardware event, cleared by a write-one pulse.
 * assumes set and clr are single-cycle pulses on the block clock.
 */
`timescale 1ns/1ns
`default_nettype none
module acpt_flag (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // flag carrier
   acpt_flag_if.owner f
);
   // set wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         f.flag <= 1'b0;
      end else if (f.set) begin
         f.flag <= 1'b1;
      end else if (f.clr) begin
         f.flag <= 1'b0;
      end
   end
endmodule // acpt_flag
`default_nettype wire

// ### acpt_tick.sv
/*
 * brings the free timer clock pin into the block clock domain and
 * gives one pulse per rising edge of it.
 * assumes the timer clock is well below half the block clock.
 */
`timescale 1ns/1ns
`default_nettype none
module acpt_tick (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // timer clock pin and edge pulse
   input wire logic i_tmr_clk,
   output logic o_tick
);
   logic sync_a;
   logic sync_b;
   logic sync_c;
   // two-stage synchroniser, then one stage for the edge; it runs
   // through reset so a pin already high at release gives no false edge
   always_ff @(posedge i_clk) begin
      sync_a <= i_tmr_clk;
      sync_b <= sync_a;
      sync_c <= sync_b;
   end
   // rising edge of the synchronised clock, held off during reset
   assign o_tick = sync_b & ~sync_c & ~i_reset;
endmodule // acpt_tick
`default_nettype wire

// ### acpt_host_model.sv
/*
 * host-side model issuing 8-bit system i/o cycles to the pm1 block.
 * assumes a registered read answer within three block clocks.
 */
`timescale 1ns/1ns
`default_nettype none
module acpt_host_model (
   // clock
   input wire logic i_clk,
   // i/o cycle toward the block
   output logic [15:0] o_addr,
   output logic o_rd,
   output logic o_wr,
   output logic [7:0] o_wdata,
   // read answer
   input wire logic [7:0] i_rdata,
   input wire logic i_hit
);
   // idle bus from time zero
   initial begin
      o_addr = 16'hffff;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_wdata = 8'h00;
   end
   // one write strobe, then scramble the released lines
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   // one read strobe, answer caught within three clocks
   task automatic io_rd(input logic [15:0] a, output logic [7:0] d,
                        output logic h);
      int k;
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk);
      #1;
      o_rd = 1'b0;
      o_addr = ~a;
      d = 8'h00;
      h = 1'b0;
      for (k = 0; k < 3 && h !== 1'b1; k++) begin
         if (i_hit === 1'b1) begin
            h = 1'b1;
            d = i_rdata;
         end else begin
            @(posedge i_clk);
            #1;
         end
      end
   endtask
endmodule // acpt_host_model
`default_nettype wire

// ### tb_top.sv
/*
 * self-checking bench for the pm1 control and timer block.
 * assumes the host model drives i/o cycles and the bench the rest.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import acpt_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tmr = 1'b0;
   logic run = 1'b1;
   logic wk = 1'b1;
   logic smi_r = 1'b0;
   logic bm = 1'b0;
   logic fwen = 1'b0;
   logic irqen = 1'b0;
   logic cclr = 1'b0;
   logic fclr = 1'b0;
   logic [15:0] base = 16'h0480;
   wire logic [15:0] addr;
   wire logic rd, wr, hit, cflag, fflag, sci_n, smi_n;
   wire logic [7:0] wdata, rdata;
   wire logic [23:0] cnt;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   int seed = 32'hadeb;
   logic [23:0] exp_cnt = 24'h00_0000;
   logic gr, fw, h;
   logic [7:0] d, q;
   logic [15:0] rsv [5] = '{16'h0003, 16'h0005, 16'h0006, 16'h0007,
                            16'h000B};
   // block under test and host model
   acpt_pm1_timer u_dut (.I_CLK(clk), .I_RESET(rst), .I_IO_ADDR(addr),
      .I_IO_RD(rd), .I_IO_WR(wr), .I_IO_WDATA(wdata), .O_IO_RDATA(rdata),
      .O_IO_HIT(hit), .I_PM1_BASE(base), .I_TMR_CLK(tmr), .I_WORKING(wk),
      .I_SMI_ROUTE_ENABLE(smi_r), .I_BUS_MASTER_CONTROL(bm),
      .I_FIRMWARE_EVENT_ENABLE(fwen), .I_TIMER_CARRY_IRQ_ENABLE(irqen),
      .I_TIMER_RUN_ENABLE(run), .I_TIMER_CARRY_CLR(cclr),
      .I_FIRMWARE_EVENT_CLR(fclr), .O_TIMER_CARRY_FLAG(cflag),
      .O_FIRMWARE_EVENT_FLAG(fflag), .O_PM_TIMER_COUNT(cnt),
      .O_SCI_N(sci_n), .O_SMI_N(smi_n));
   acpt_host_model u_host (.i_clk(clk), .o_addr(addr), .o_rd(rd),
      .o_wr(wr), .o_wdata(wdata), .i_rdata(rdata), .i_hit(hit));
   // 50 mhz block clock
   initial begin
      forever #10 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   // compare and count
   task automatic chk(input string n, input logic [23:0] s,
                      input logic [23:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // verdict and end of run
   task automatic wrap_up;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // timer clock pulses near 3.58 mhz, still between bursts
   task automatic ticks(input int n);
      repeat (n) begin
         repeat (7) @(posedge clk);
         #1 tmr = 1'b1;
         if (run && wk)
            exp_cnt = exp_cnt + 24'h00_0001;
         repeat (7) @(posedge clk);
         #1 tmr = 1'b0;
      end
      repeat (7) @(posedge clk);
   endtask
   // timer bytes and count output against the bench count
   task automatic chk_tmr;
      for (int i = 0; i < 3; i++) begin
         u_host.io_rd(base + OFS_TMR_BYTE_LOW + 16'(i), q, h);
         chk("tmr_byte", 24'({h, q}), 24'({1'b1, exp_cnt[8*i+:8]}));
      end
      chk("count", cnt, exp_cnt);
   endtask
   // firmware clear pulse
   task automatic fw_clear;
      @(posedge clk);
      #1 fclr = 1'b1;
      @(posedge clk);
      #1 fclr = 1'b0;
      gr = 1'b0;
      fw = 1'b0;
   endtask
   // expected active-low pin level for a cause
   function automatic logic [23:0] exp_pin(input logic cause);
      exp_pin = 24'(!cause);
   endfunction
   // expected hit and data of a main control read
   function automatic logic [23:0] exp_ctl(input logic g,
                                           input logic [1:0] b);
      exp_ctl = 24'({4'h1, 5'h00, g, b});
   endfunction
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      chk_tmr();
      chk("sci_n", 24'(sci_n), 24'h00_0001);
      for (int b = 0; b < 2; b++) begin
         base = b ? 16'h0c10 : 16'h0480;
         foreach (rsv[i]) begin
            u_host.io_wr(base + rsv[i], 8'($random(seed)));
            u_host.io_rd(base + rsv[i], q, h);
            chk("reserved", 24'({h, q}), 24'h00_0100);
         end
         u_host.io_rd(base + 16'h0002, q, h);
         chk("outside", 24'({h, q}), 24'h00_0000);
         u_host.io_rd(base + 16'h000C, q, h);
         chk("outside", 24'({h, q}), 24'h00_0000);
         ticks(1 + ($unsigned($random(seed)) % 40));
         for (int i = 0; i < 3; i++)
            u_host.io_wr(base + OFS_TMR_BYTE_LOW + 16'(i), 8'($random(seed)));
         chk_tmr();
      end
      run = 1'b0;
      ticks(5);
      chk_tmr();
      run = 1'b1;
      wk = 1'b0;
      ticks(5);
      chk_tmr();
      wk = 1'b1;
      ticks(3);
      chk_tmr();
      fw_clear();
      for (int i = 0; i < 24; i++) begin
         {smi_r, bm, fwen, irqen} = 4'($random(seed));
         d = 8'($random(seed));
         u_host.io_wr(base + OFS_PM1_CTL_MAIN, d);
         gr = gr | d[2];
         fw = fw | d[2];
         if (i % 3 == 2)
            fw_clear();
         cclr = i[0];
         @(posedge clk);
         #1 cclr = 1'b0;
         repeat (2) @(posedge clk);
         #1;
         chk("sci_n", 24'(sci_n), exp_pin(d[1] & bm));
         chk("smi_n", 24'(smi_n), exp_pin(fw & fwen));
         chk("fw_flag", 24'(fflag), 24'(fw));
         chk("carry", 24'(cflag), 24'h00_0000);
         u_host.io_rd(base + OFS_PM1_CTL_MAIN, q, h);
         chk("ctl_main", 24'({h, q}), exp_ctl(gr, d[1:0]));
      end
      ticks(4);
      @(posedge clk);
      #1 rst = 1'b1;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      exp_cnt = 24'h00_0000;
      chk_tmr();
      chk("fw_flag", 24'(fflag), 24'h00_0000);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
